// File: design/scp_serial_port.sv
// Chosen here: the plain strobed port and the placing of the registers.
`include "scp_serial_regs.svh"
`default_nettype none

// Summary of operation
// - Controller selected only while I/O address lies in ECH to EFH.
// - Address bit zero high means control byte, low means data character.
// - Control byte latched on selected output to port ED or EF.
// - First control byte after reset or internal reset is the mode word, later ones are command words.
// - Mode word picks sync/async, baud factor, length, stop bits, parity.
// - Command word sets enables, error clear, terminal-ready, request-to-send, reset.
// - High reset input resets the controller.
// - Transmit ready high while the holding register is empty, transmit enable is set and clear-to-send is asserted.
// - Transmit ready clears when the processor writes a data character.
// - Receive ready rises after a whole character has arrived.
// - Receive ready clears when the processor reads the character.
// - Sending starts only with transmit enable set and clear-to-send asserted.
// - Reset holds the serial output marking.
// - Baud clock from three cascaded 4-bit counters, tap chosen by the synchronised baud_sel pins, which may change at run time.
// - Two further counters make a 1.024 ms or 10.24 ms tick.
// - Characters and control words travel over an eight-bit bus.
// - Baud generator runs from the oscillator clock.
module scp_serial_port #(
    parameter int TICK_SHORT_CYC = `SCP_TICK_SHORT_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output logic      [7:0] io_rdata,
    input  wire logic [1:0] baud_sel,
    input  wire logic       tick_long,
    input  wire logic       rxd,
    input  wire logic       cts_n,
    output logic            txd,
    output logic            dtr_n,
    output logic            rts_n,
    output logic            transmit_ready,
    output logic            receive_ready,
    output logic            timer_tick,
    output logic            irq
);
    localparam int TICK_DIV = TICK_SHORT_CYC / 16;

    if (TICK_SHORT_CYC < 32 || TICK_SHORT_CYC % 16 != 0 || TICK_DIV > 65536) begin : g_chk
        $error("TICK_SHORT_CYC must be a multiple of 16 from 32 to 1048576");
    end

    function automatic logic [6:0] bit_ticks(input logic [1:0] f);
        case (f)
            2'b10:   bit_ticks = 7'h10;
            2'b11:   bit_ticks = 7'h40;
            default: bit_ticks = 7'h01;
        endcase
    endfunction

    function automatic logic [7:0] stop_ticks(input logic [1:0] s, input logic [6:0] b);
        case (s)
            2'b10:   stop_ticks = {1'b0, b} + {2'b00, b[6:1]};
            2'b11:   stop_ticks = {b, 1'b0};
            default: stop_ticks = {1'b0, b};
        endcase
    endfunction

    function automatic logic [7:0] char_mask(input logic [1:0] len);
        char_mask = 8'hFF >> (2'h3 - len);
    endfunction

    // Pin synchronisers
    logic [1:0] rxd_m, cts_m, bsel_m0, bsel_m1;
    logic       tlong_m0, tlong_m1;
    logic       rxd_s, cts_s;
    logic [1:0] bsel_s;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxd_m    <= 2'h3;
            cts_m    <= 2'h0;
            bsel_m0  <= 2'h0;
            bsel_m1  <= 2'h0;
            tlong_m0 <= 1'b0;
            tlong_m1 <= 1'b0;
        end else begin
            rxd_m    <= {rxd_m[0], rxd};
            cts_m    <= {cts_m[0], ~cts_n};
            bsel_m0  <= baud_sel;
            bsel_m1  <= bsel_m0;
            tlong_m0 <= tick_long;
            tlong_m1 <= tlong_m0;
        end
    end
    assign rxd_s  = rxd_m[1];
    assign cts_s  = cts_m[1];
    assign bsel_s = bsel_m1;

    // Baud generator: sys_clk stands in for the oscillator clock
    logic [`SCP_STAGE_W-1:0] stg0_q, stg1_q, stg2_q;
    logic c0, c1, c2, bclk;
    assign c0 = (stg0_q == 4'hF);
    assign c1 = c0 && (stg1_q == 4'hF);
    assign c2 = c1 && (stg2_q == 4'hF);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stg0_q <= 4'h0;
            stg1_q <= 4'h0;
            stg2_q <= 4'h0;
        end else begin
            stg0_q <= stg0_q + 4'h1;
            if (c0)
                stg1_q <= stg1_q + 4'h1;
            if (c1)
                stg2_q <= stg2_q + 4'h1;
        end
    end
    always_comb begin
        case (bsel_s)
            2'b00:   bclk = c0;
            2'b01:   bclk = c1;
            2'b10:   bclk = c2;
            default: bclk = 1'b1;
        endcase
    end

    // Periodic tick: short counter on first-stage carries, decade counter above
    logic [15:0] tdiv_q;
    logic [3:0]  tdec_q;
    logic        tick_q;
    logic        short_end;
    assign short_end = c0 && (tdiv_q == 16'(TICK_DIV - 1));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tdiv_q <= 16'h0000;
            tdec_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (c0)
                tdiv_q <= short_end ? 16'h0000 : tdiv_q + 16'h0001;
            if (short_end) begin
                tdec_q <= (tdec_q == 4'(`SCP_TICK_LONG_MUL - 1)) ? 4'h0 : tdec_q + 4'h1;
                tick_q <= !tlong_m1 || (tdec_q == 4'(`SCP_TICK_LONG_MUL - 1));
            end
        end
    end
    assign timer_tick = tick_q;

    // Bus decode
    logic sel, wr_data, wr_ctrl, rd_data, rd_ctrl;
    assign sel     = (io_addr[7:2] == `SCP_SEL_BASE);
    assign wr_data = sel && io_wr && !io_addr[0];
    assign wr_ctrl = sel && io_wr && io_addr[0];
    assign rd_data = sel && io_rd && !io_addr[0];
    assign rd_ctrl = sel && io_rd && io_addr[0];

    // Programming sequence
    scp_pkg::scp_prog_t prog_q;
    logic [7:0] mode_q, cmd_q;
    logic       ireset;
    assign ireset = wr_ctrl && (prog_q == scp_pkg::PROG_CMD) && io_wdata[`SCP_CMD_IRESET];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prog_q <= scp_pkg::PROG_MODE;
            mode_q <= `SCP_MODE_RST;
            cmd_q  <= `SCP_CMD_RST;
        end else if (wr_ctrl) begin
            case (prog_q)
                scp_pkg::PROG_MODE: begin
                    mode_q <= io_wdata;
                    prog_q <= scp_pkg::PROG_CMD;
                end
                scp_pkg::PROG_CMD: begin
                    if (ireset) begin
                        cmd_q  <= `SCP_CMD_RST;
                        prog_q <= scp_pkg::PROG_MODE;
                    end else begin
                        cmd_q  <= io_wdata;
                    end
                end
                default: prog_q <= scp_pkg::PROG_MODE;
            endcase
        end
    end

    logic       sync_mode, pen, peven;
    logic [1:0] clen;
    logic [6:0] bt;
    logic [7:0] st;
    assign sync_mode = (mode_q[`SCP_MODE_FACT_LO +: 2] == 2'b00);
    assign clen      = mode_q[`SCP_MODE_LEN_LO +: 2];
    assign pen       = mode_q[`SCP_MODE_PEN];
    assign peven     = mode_q[`SCP_MODE_PEVEN];
    assign bt        = bit_ticks(mode_q[`SCP_MODE_FACT_LO +: 2]);
    assign st        = stop_ticks(mode_q[`SCP_MODE_STOP_LO +: 2], bt);

    // Transmitter with holding register
    scp_pkg::scp_tx_t tx_q;
    logic [7:0] hold_q, tsh_q, tcnt_q;
    logic [2:0] tbit_q;
    logic       hold_full_q, line_q, tx_load, tstep, tpar_q;
    assign tx_load = bclk && (tx_q == scp_pkg::TX_IDLE) && hold_full_q
                     && cmd_q[`SCP_CMD_TRANSMIT_ENABLE_BIT] && cts_s;
    assign tstep   = bclk && (tcnt_q == {1'b0, bt} - 8'h01);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_q        <= scp_pkg::TX_IDLE;
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
            tsh_q       <= 8'h00;
            tcnt_q      <= 8'h00;
            tbit_q      <= 3'h0;
            tpar_q      <= 1'b0;
            line_q      <= 1'b1;
        end else if (ireset) begin
            tx_q        <= scp_pkg::TX_IDLE;
            hold_full_q <= 1'b0;
            line_q      <= 1'b1;
        end else begin
            if (wr_data) begin
                hold_q      <= io_wdata;
                hold_full_q <= 1'b1;
            end else if (tx_load) begin
                hold_full_q <= 1'b0;
            end
            if (bclk && tx_q != scp_pkg::TX_IDLE)
                tcnt_q <= tstep ? 8'h00 : tcnt_q + 8'h01;
            case (tx_q)
                scp_pkg::TX_IDLE: begin
                    line_q <= 1'b1;
                    if (tx_load) begin
                        tsh_q  <= hold_q & char_mask(clen);
                        tcnt_q <= 8'h00;
                        tbit_q <= 3'h0;
                        // Parity fixed at load: the holding register may refill mid-character
                        tpar_q <= ^(hold_q & char_mask(clen)) ^ !peven;
                        if (sync_mode) begin
                            line_q <= hold_q[0];
                            tx_q   <= scp_pkg::TX_DATA;
                        end else begin
                            line_q <= 1'b0;
                            tx_q   <= scp_pkg::TX_START;
                        end
                    end
                end
                scp_pkg::TX_START: if (tstep) begin
                    line_q <= tsh_q[0];
                    tx_q   <= scp_pkg::TX_DATA;
                end
                scp_pkg::TX_DATA: if (tstep) begin
                    tsh_q  <= {1'b0, tsh_q[7:1]};
                    tbit_q <= tbit_q + 3'h1;
                    line_q <= tsh_q[1];
                    if (tbit_q == {1'b1, clen}) begin
                        if (pen) begin
                            line_q <= tpar_q;
                            tx_q   <= scp_pkg::TX_PAR;
                        end else if (sync_mode) begin
                            line_q <= 1'b1;
                            tx_q   <= scp_pkg::TX_IDLE;
                        end else begin
                            line_q <= 1'b1;
                            tx_q   <= scp_pkg::TX_STOP;
                        end
                    end
                end
                scp_pkg::TX_PAR: if (tstep) begin
                    line_q <= 1'b1;
                    tx_q   <= sync_mode ? scp_pkg::TX_IDLE : scp_pkg::TX_STOP;
                end
                scp_pkg::TX_STOP: begin
                    if (bclk && tcnt_q >= st - 8'h01) begin
                        tcnt_q <= 8'h00;
                        tx_q   <= scp_pkg::TX_IDLE;
                    end
                end
                default: tx_q <= scp_pkg::TX_IDLE;
            endcase
        end
    end

    // Line and modem outputs, break forces spacing
    logic txd_q, dtr_q, rts_q, transmit_ready_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txd_q   <= 1'b1;
            dtr_q   <= 1'b1;
            rts_q   <= 1'b1;
            transmit_ready_q <= 1'b0;
        end else begin
            txd_q   <= line_q && !cmd_q[`SCP_CMD_BREAK];
            dtr_q   <= !cmd_q[`SCP_CMD_DTR];
            rts_q   <= !cmd_q[`SCP_CMD_RTS];
            transmit_ready_q <= !hold_full_q && !wr_data && !tx_load && !ireset
                       && cmd_q[`SCP_CMD_TRANSMIT_ENABLE_BIT] && cts_s;
        end
    end
    assign txd            = txd_q;
    assign dtr_n          = dtr_q;
    assign rts_n          = rts_q;
    assign transmit_ready = transmit_ready_q;

    // Receiver, async only; samples at bit centre
    scp_pkg::scp_rx_t rx_q;
    logic [7:0] rsh_q, rcnt_q, rword_q;
    logic [2:0] rbit_q;
    logic       rpar_q, rdone_q, rperr_q, rferr_q, rsamp;
    assign rsamp = bclk && (rcnt_q == {1'b0, bt} - 8'h01);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_q    <= scp_pkg::RX_IDLE;
            rsh_q   <= 8'h00;
            rcnt_q  <= 8'h00;
            rbit_q  <= 3'h0;
            rpar_q  <= 1'b0;
            rword_q <= 8'h00;
            rdone_q <= 1'b0;
            rperr_q <= 1'b0;
            rferr_q <= 1'b0;
        end else begin
            rdone_q <= 1'b0;
            if (ireset || !cmd_q[`SCP_CMD_RXEN] || sync_mode) begin
                rx_q <= scp_pkg::RX_IDLE;
            end else begin
                if (bclk && rx_q != scp_pkg::RX_IDLE)
                    rcnt_q <= rsamp ? 8'h00 : rcnt_q + 8'h01;
                case (rx_q)
                    scp_pkg::RX_IDLE: if (bclk && !rxd_s) begin
                        rcnt_q <= 8'h00;
                        rx_q   <= scp_pkg::RX_START;
                    end
                    scp_pkg::RX_START: begin
                        if (bclk && rcnt_q == {2'b00, bt[6:1]}) begin
                            rcnt_q <= 8'h00;
                            rbit_q <= 3'h0;
                            rx_q   <= rxd_s ? scp_pkg::RX_IDLE : scp_pkg::RX_DATA;
                        end
                    end
                    scp_pkg::RX_DATA: if (rsamp) begin
                        rsh_q  <= {rxd_s, rsh_q[7:1]};
                        rbit_q <= rbit_q + 3'h1;
                        if (rbit_q == {1'b1, clen})
                            rx_q <= pen ? scp_pkg::RX_PAR : scp_pkg::RX_STOP;
                    end
                    scp_pkg::RX_PAR: if (rsamp) begin
                        rpar_q <= rxd_s;
                        rx_q   <= scp_pkg::RX_STOP;
                    end
                    scp_pkg::RX_STOP: if (rsamp) begin
                        rword_q <= rsh_q >> (2'h3 - clen);
                        rperr_q <= pen && ((^(rsh_q >> (2'h3 - clen)) ^ rpar_q) == peven);
                        rferr_q <= !rxd_s;
                        rdone_q <= 1'b1;
                        rx_q    <= scp_pkg::RX_IDLE;
                    end
                    default: rx_q <= scp_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer and sticky errors; an arriving character beats a clear
    logic [7:0] rbuf_q;
    logic       receive_ready_q, perr_q, oerr_q, ferr_q, errclr, err_evt;
    assign errclr  = ireset || (wr_ctrl && prog_q == scp_pkg::PROG_CMD
                                && io_wdata[`SCP_CMD_ERRCLR]);
    assign err_evt = rdone_q && (rperr_q || rferr_q || receive_ready_q);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rbuf_q  <= 8'h00;
            receive_ready_q <= 1'b0;
            perr_q  <= 1'b0;
            oerr_q  <= 1'b0;
            ferr_q  <= 1'b0;
        end else begin
            if (rdone_q) begin
                rbuf_q  <= rword_q;
                receive_ready_q <= 1'b1;
            end else if (rd_data || ireset) begin
                receive_ready_q <= 1'b0;
            end
            if (errclr) begin
                perr_q <= 1'b0;
                oerr_q <= 1'b0;
                ferr_q <= 1'b0;
            end
            if (rdone_q) begin
                if (rperr_q)
                    perr_q <= 1'b1;
                if (receive_ready_q)
                    oerr_q <= 1'b1;
                if (rferr_q)
                    ferr_q <= 1'b1;
            end
        end
    end
    assign receive_ready = receive_ready_q;

    // Interrupt status, clear and enable
    logic [3:0] ist_q, ien_q, ievt;
    logic       irq_q;
    assign ievt = {tick_q, err_evt, tx_load, rdone_q};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ist_q <= 4'h0;
            ien_q <= `SCP_IRQ_EN_RST;
            irq_q <= 1'b0;
        end else begin
            if (io_wr && io_addr == `SCP_PORT_IRQ_EN)
                ien_q <= io_wdata[3:0];
            if (io_wr && io_addr == `SCP_PORT_IRQ_CLR)
                ist_q <= (ist_q & ~io_wdata[3:0]) | ievt;
            else
                ist_q <= ist_q | ievt;
            irq_q <= |(ist_q & ien_q);
        end
    end
    assign irq = irq_q;

    // Read data, one cycle after the strobe
    logic [7:0] rdata_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (io_rd) begin
            if (rd_data)
                rdata_q <= rbuf_q;
            else if (rd_ctrl)
                rdata_q <= {2'b00, ferr_q, oerr_q, perr_q,
                            !hold_full_q && tx_q == scp_pkg::TX_IDLE, receive_ready_q, !hold_full_q};
            else if (io_addr == `SCP_PORT_IRQ_STAT)
                rdata_q <= {4'h0, ist_q};
            else if (io_addr == `SCP_PORT_IRQ_EN)
                rdata_q <= {4'h0, ien_q};
            else
                rdata_q <= 8'h00;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign io_rdata = rdata_q;

    // Checks
    a_sel_range: assert property (@(posedge sys_clk) disable iff (rst)
        (io_wr && io_addr[7:2] != `SCP_SEL_BASE) |=> $stable(mode_q) && $stable(cmd_q))
        else $error("control changed by unselected write");
    a_mode_first: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_ctrl && prog_q == scp_pkg::PROG_MODE)
        |=> (mode_q == $past(io_wdata)) && prog_q == scp_pkg::PROG_CMD)
        else $error("mode word not taken first");
    a_data_not_ctrl: assert property (@(posedge sys_clk) disable iff (rst)
        wr_data |=> $stable(mode_q) && $stable(cmd_q) && hold_full_q)
        else $error("data write misrouted");
    a_transmit_ready_clear: assert property (@(posedge sys_clk) disable iff (rst)
        wr_data |=> !transmit_ready ##1 !transmit_ready)
        else $error("transmit ready stayed after data write");
    a_receive_ready_set: assert property (@(posedge sys_clk) disable iff (rst)
        rdone_q |=> receive_ready && rbuf_q == $past(rword_q))
        else $error("receive ready not raised");
    a_receive_ready_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_data && !rdone_q) |=> !receive_ready)
        else $error("receive ready not cleared on read");
    a_tx_gate: assert property (@(posedge sys_clk) disable iff (rst)
        ($past(tx_q) == scp_pkg::TX_IDLE && tx_q != scp_pkg::TX_IDLE)
        |-> $past(cmd_q[`SCP_CMD_TRANSMIT_ENABLE_BIT] && cts_s))
        else $error("transmission began without enable and clear-to-send");
    a_mark_reset: assert property (@(posedge sys_clk)
        (!rst && $past(rst)) |-> txd ##1 txd)
        else $error("line not marking after reset");
    a_err_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (errclr && !rdone_q) |=> !perr_q && !oerr_q && !ferr_q)
        else $error("error flags not cleared");
    a_tick_gap: assert property (@(posedge sys_clk) disable iff (rst)
        timer_tick |=> (!timer_tick)[*8])
        else $error("tick pulses too close");
endmodule // scp_serial_port

`default_nettype wire

// File: design/scp_serial_regs.svh
`ifndef SCP_SERIAL_REGS_SVH
`define SCP_SERIAL_REGS_SVH

// Port addresses on the 8-bit I/O space
`define SCP_SEL_BASE        6'h3B
`define SCP_PORT_DATA       8'hEC
`define SCP_PORT_CTRL       8'hED
`define SCP_PORT_IRQ_STAT   8'hE0
`define SCP_PORT_IRQ_CLR    8'hE1
`define SCP_PORT_IRQ_EN     8'hE2

// Mode word fields
`define SCP_MODE_FACT_LO    0
`define SCP_MODE_LEN_LO     2
`define SCP_MODE_PEN        4
`define SCP_MODE_PEVEN      5
`define SCP_MODE_STOP_LO    6

// Command word fields
`define SCP_CMD_TRANSMIT_ENABLE_BIT        0
`define SCP_CMD_DTR         1
`define SCP_CMD_RXEN        2
`define SCP_CMD_BREAK       3
`define SCP_CMD_ERRCLR      4
`define SCP_CMD_RTS         5
`define SCP_CMD_IRESET      6

// Interrupt status bits
`define SCP_IRQ_RX          0
`define SCP_IRQ_TX          1
`define SCP_IRQ_ERR         2
`define SCP_IRQ_TICK        3

// Reset values
`define SCP_MODE_RST        8'h00
`define SCP_CMD_RST         8'h00
`define SCP_IRQ_EN_RST      4'h0

// Timing
`define SCP_CLK_NS          50
`define SCP_TICK_SHORT_NS   1024000
`define SCP_TICK_SHORT_CYC  (`SCP_TICK_SHORT_NS / `SCP_CLK_NS)
`define SCP_TICK_LONG_MUL   10
`define SCP_STAGE_W         4

`endif

// File: design/scp_pkg.sv
`default_nettype none
package scp_pkg;
    typedef enum logic [0:0] {PROG_MODE, PROG_CMD} scp_prog_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scp_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scp_rx_t;
endpackage
`default_nettype wire

// File: verif/scp_link_partner.sv
`default_nettype none
module scp_link_partner #(
    parameter int BIT_CYC = 16
) (
    input  wire logic       sys_clk,
    input  wire logic       txd,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    output logic            rxd,
    output logic      [7:0] got_byte,
    output logic            got_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] frame;
    // Start, eight data bits LSB first, stop; the line marks between frames
    initial begin
        rxd = 1'b1;
        forever begin
            @(posedge sys_clk);
            if (send === 1'b1) begin
                frame = {1'b1, send_byte, 1'b0};
                for (int i = 0; i < 10; i++) begin
                    rxd <= frame[i];
                    repeat (BIT_CYC) @(posedge sys_clk);
                end
            end
        end
    end
    // Mid-bit sampling; a frame counts only if its stop bit is marking
    initial begin
        got_valid = 1'b0;
        got_byte = 8'h00;
        forever begin
            @(posedge sys_clk);
            got_valid <= 1'b0;
            if (txd === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge sys_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge sys_clk);
                    got_byte[i] <= txd;
                end
                repeat (BIT_CYC) @(posedge sys_clk);
                got_valid <= (txd === 1'b1);
            end
        end
    end
endmodule // scp_link_partner
`default_nettype wire

// File: verif/test_serial_comm_port.sv
`default_nettype none
module test_serial_comm_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic  [7:0] io_addr = 8'h00;
    logic  [7:0] io_wdata = 8'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic        cts_n = 1'b1;
    logic  [1:0] baud_sel = 2'h3;
    logic        tick_long = 1'b0;
    logic        send = 1'b0;
    logic  [7:0] send_byte = 8'h00;
    logic  [7:0] io_rdata, got_byte, rdat;
    logic        rxd, txd, dtr_n, rts_n, transmit_ready, receive_ready, timer_tick, irq;
    logic        got_valid;
    int          bad_count = 0;
    int          checks = 0;
    int unsigned seed = 14;
    byte unsigned tx_q[$];
    byte unsigned rx_q[$];

    always #25 sys_clk = ~sys_clk;

    scp_serial_port #(.TICK_SHORT_CYC(64)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .baud_sel(baud_sel),
        .tick_long(tick_long), .rxd(rxd), .cts_n(cts_n), .txd(txd), .dtr_n(dtr_n),
        .rts_n(rts_n), .transmit_ready(transmit_ready), .receive_ready(receive_ready),
        .timer_tick(timer_tick), .irq(irq));

    scp_link_partner #(.BIT_CYC(16)) link_u (
        .sys_clk(sys_clk), .txd(txd), .send(send), .send_byte(send_byte),
        .rxd(rxd), .got_byte(got_byte), .got_valid(got_valid));

    function automatic logic [7:0] rand8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1 rdat = io_rdata;
    endtask

    // One-cycle request; the partner only looks for it between frames
    task automatic put_char(input logic [7:0] d);
        @(posedge sys_clk);
        send <= 1'b1;
        send_byte <= d;
        @(posedge sys_clk);
        send <= 1'b0;
    endtask

    // Waits for one of: 0 transmit ready, 1 receive ready, 2 frame seen, 3 tick
    task automatic wait_on(input int sel, input int lim, output int n);
        logic [3:0] v;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
            v = {timer_tick, got_valid, receive_ready, transmit_ready};
        end while (v[sel] !== 1'b1 && n < lim);
        if (v[sel] !== 1'b1) begin
            bad_count++;
            $display("unexpected wait %0d: expected 1 seen 0", sel);
            complete_run();
        end
    endtask

    initial begin
        int n;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk("idle pins", 8'h38,
            {2'h0, txd, dtr_n, rts_n, transmit_ready, receive_ready, irq});
        rd(8'hEB);
        chk("unmapped read", 8'h00, rdat);
        wr(8'hED, 8'h4E);
        wr(8'hEF, 8'h37);
        repeat (4) @(posedge sys_clk);
        #1 chk("modem pins", 8'h00, {6'h0, dtr_n, rts_n});
        rd(8'hED);
        chk("status", 8'h05, rdat);
        $display("test setup done");
        tx_q.push_back(rand8());
        tx_q.push_back(rand8());
        wr(8'hEC, tx_q[0]);
        n = 0;
        repeat (200) begin
            @(posedge sys_clk);
            n += int'(txd === 1'b0);
        end
        chk("txd low cycles", 8'h00, n[7:0]);
        cts_n <= 1'b0;
        wait_on(0, 20, n);
        wr(8'hEE, tx_q[1]);
        repeat (3) @(posedge sys_clk);
        #1 chk("transmit ready", 8'h00, {7'h0, transmit_ready});
        repeat (2) begin
            wait_on(2, 400, n);
            chk("tx char", tx_q.pop_front(), got_byte);
        end
        $display("test transmit done");
        for (int i = 0; i < 2; i++) begin
            wr(8'hE2, i[7:0]);
            rx_q.push_back(rand8());
            put_char(rx_q[0]);
            wait_on(1, 400, n);
            repeat (2) @(posedge sys_clk);
            #1 chk("irq", i[7:0], {7'h0, irq});
            rd(8'hEC);
            chk("rx char", rx_q.pop_front(), rdat);
            @(posedge sys_clk);
            #1 chk("receive ready", 8'h00, {7'h0, receive_ready});
            wr(8'hE1, 8'h0F);
            repeat (2) @(posedge sys_clk);
            #1 chk("irq cleared", 8'h00, {7'h0, irq});
        end
        repeat (2) begin
            rx_q.push_front(rand8());
            put_char(rx_q[0]);
            repeat (180) @(posedge sys_clk);
        end
        rd(8'hED);
        chk("overrun status", 8'h17, rdat);
        wr(8'hEF, 8'h37);
        rd(8'hEF);
        chk("status after error reset", 8'h07, rdat);
        rd(8'hEC);
        chk("overwritten char", rx_q.pop_front(), rdat);
        $display("test receive done");
        wait_on(3, 200, n);
        wait_on(3, 200, n);
        chk("tick period", 8'h40, n[7:0]);
        @(posedge sys_clk) tick_long <= 1'b1;
        wait_on(3, 700, n);
        wait_on(3, 700, n);
        chk("long tick period", 8'h80, n[7:0]);
        $display("test tick done");
        wr(8'hEF, 8'h40);
        repeat (3) @(posedge sys_clk);
        #1 chk("modem after reset", 8'h03, {6'h0, dtr_n, rts_n});
        @(posedge sys_clk) baud_sel <= 2'h0;
        wr(8'hED, 8'h4D);
        wr(8'hEF, 8'h03);
        repeat (3) @(posedge sys_clk);
        #1 chk("modem reprogram", 8'h01, {6'h0, dtr_n, rts_n});
        tx_q.push_back(rand8());
        wr(8'hEC, tx_q[0]);
        wait_on(2, 400, n);
        chk("slow tap char", tx_q.pop_front(), got_byte);
        $display("test internal reset done");
        complete_run();
    end
endmodule // test_serial_comm_port
`default_nettype wire
